// File: common/adcsc_pkg.sv
// Constants, register map and state encoding for the converter serial output control block.
`default_nettype none
package adcsc_pkg;
  localparam int          WORD_W           = 16;
  localparam int          UART_LEN         = 22;
  localparam logic [4:0]  UART_LEN_C       = 5'h16;
  localparam logic [4:0]  SYNC_LEN_C       = 5'h10;
  localparam logic [2:0]  TRIM_HOLD_CYC    = 3'h4;
  localparam logic [2:0]  BLANK_CYC        = 3'h4;
  localparam logic [1:0]  SCLK_LAST_PHASE  = 2'h3;
  localparam logic [15:0] CAL_LEN_RST      = 16'h0040;
  localparam logic [1:0]  MODE_UART        = 2'h0;
  localparam logic [1:0]  MODE_EXT         = 2'h1;
  localparam logic [1:0]  MODE_SELF        = 2'h2;
  localparam logic [7:0]  OFS_STATUS       = 8'h00;
  localparam logic [7:0]  OFS_MASK         = 8'h04;
  localparam logic [7:0]  OFS_STATE        = 8'h08;
  localparam logic [7:0]  OFS_LAST_WORD    = 8'h0c;
  localparam logic [7:0]  OFS_CAL_LEN      = 8'h10;
  localparam int          EVT_W            = 4;
  localparam int          EVT_LOAD         = 0;
  localparam int          EVT_TX_DONE      = 1;
  localparam int          EVT_RESET        = 2;
  localparam int          EVT_CAL_DONE     = 3;
  localparam int          PIN_W            = 9;
  localparam int          PIN_PWR          = 0;
  localparam int          PIN_POL          = 1;
  localparam int          PIN_TRIM         = 2;
  localparam int          PIN_SEL_A        = 3;
  localparam int          PIN_SEL_B        = 4;
  localparam int          PIN_MODE_LO      = 5;
  localparam int          PIN_MODE_HI      = 6;
  localparam int          PIN_CS_N         = 7;
  localparam int          PIN_SCLK         = 8;
  typedef enum logic [3:0] {
    ADCSC_RUN   = 4'b0001,
    ADCSC_SLEEP = 4'b0010,
    ADCSC_RESET = 4'b0100,
    ADCSC_CAL   = 4'b1000
  } adcsc_state_e;
endpackage
`default_nettype wire

// File: design/adcsc_top.sv
// Control pins, calibration sequencing and serial word output of the converter.
//
// Contract
// - Low power_down_n puts the device into its low power sleep state.
// - polarity_select low means unipolar range, high means bipolar range.
// - trim_request high for more than four clock cycles resets the device.
// - When trim_request falls after that reset, one calibration cycle runs.
// - trim_request may strobe several devices; each reacts identically and deterministically.
// - Host drives unit_select_n low to request data; device then starts sending.
// - word_valid_n is low while a valid word sits in the output register.
// - word_valid_n goes high once the current word has been fully sent.
// - Loading a new word forces word_valid_n high for four clock cycles.
// - serial_bit_clock is input or output depending on the selected mode.
// - Self clocked mode drives serial_bit_clock at clock over four, 25% high.
// - Each result leaves serial_out_line as a 16-bit serial word.
// - Mode selects uart framed, external clocked or self clocked operation.
// - Uart framed mode sends two bytes, each with one start and two stops.
// - External clocked mode sends the word unframed, most significant bit first.
// - sys_trim_sel_a and sys_trim_sel_b at trim_request rise pick calibration type.
//
// The Wishbone register port and the register offsets are this design's own decisions.
`default_nettype none
module adcsc_top
  import adcsc_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq_o,
  input  wire logic        power_down_n_i,
  input  wire logic        polarity_select_i,
  input  wire logic        trim_request_i,
  input  wire logic        sys_trim_sel_a_i,
  input  wire logic        sys_trim_sel_b_i,
  input  wire logic [1:0]  mode_sel_i,
  input  wire logic        unit_select_n_i,
  input  wire logic        serial_bit_clock_i,
  output logic             serial_bit_clock_o,
  output logic             serial_bit_clock_oe_o,
  output logic             serial_out_line_o,
  output logic             serial_out_line_oe_o,
  output logic             word_valid_n_o,
  input  wire logic [15:0] conv_word_i,
  input  wire logic        conv_strobe_i,
  output logic             sleep_o,
  output logic             bipolar_o,
  output logic             cal_busy_o,
  output logic [1:0]       cal_type_o
);

  // Pin synchronisers: three stages, a change counts when stages two and three agree.
  logic [PIN_W-1:0] sync1_reg;
  logic [PIN_W-1:0] sync2_reg;
  logic [PIN_W-1:0] sync3_reg;
  logic [PIN_W-1:0] pin_reg;
  wire  [PIN_W-1:0] pin_raw;

  assign pin_raw = {serial_bit_clock_i, unit_select_n_i, mode_sel_i, sys_trim_sel_b_i,
                    sys_trim_sel_a_i, trim_request_i, polarity_select_i, power_down_n_i};

  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        sync1_reg[gi] <= pin_raw[gi];
        sync2_reg[gi] <= sync1_reg[gi];
        sync3_reg[gi] <= sync2_reg[gi];
        if (rst_i) begin
          // Power and unit select pins leave reset at their idle high level.
          pin_reg[gi] <= (gi == PIN_PWR) || (gi == PIN_CS_N);
        end else if (sync2_reg[gi] == sync3_reg[gi]) begin
          pin_reg[gi] <= sync3_reg[gi];
        end
      end
    end
  endgenerate

  wire       pwr_on   = pin_reg[PIN_PWR];
  wire       trim     = pin_reg[PIN_TRIM];
  wire [1:0] mode     = pin_reg[PIN_MODE_HI:PIN_MODE_LO];
  wire       cs_n     = pin_reg[PIN_CS_N];
  wire       sclk_in  = pin_reg[PIN_SCLK];
  wire       m_uart   = (mode == MODE_UART);
  wire       m_ext    = (mode == MODE_EXT);
  wire       m_self   = !m_uart && !m_ext;

  // Control state machine.
  adcsc_state_e state_reg;
  adcsc_state_e state_next;
  logic [2:0]   trim_cnt_reg;
  logic         trim_prev_reg;
  logic [15:0]  cal_cnt_reg;
  logic [15:0]  cal_len_reg;
  logic [1:0]   cal_type_reg;
  logic         polarity_reg;

  wire trim_rise = trim && !trim_prev_reg;
  wire trim_long = trim && (trim_cnt_reg == TRIM_HOLD_CYC);
  wire cal_end   = (state_reg == ADCSC_CAL) && (cal_cnt_reg >= cal_len_reg);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ADCSC_RUN: begin
        if (trim_long) begin
          state_next = ADCSC_RESET;
        end else if (!pwr_on) begin
          state_next = ADCSC_SLEEP;
        end
      end
      ADCSC_SLEEP: begin
        if (trim_long) begin
          state_next = ADCSC_RESET;
        end else if (pwr_on) begin
          state_next = ADCSC_RUN;
        end
      end
      ADCSC_RESET: begin
        if (!trim) begin
          state_next = ADCSC_CAL;
        end
      end
      ADCSC_CAL: begin
        if (trim_long) begin
          state_next = ADCSC_RESET;
        end else if (cal_end) begin
          state_next = ADCSC_RUN;
        end
      end
      default: begin
        state_next = ADCSC_RUN;
      end
    endcase
  end

  wire enter_reset = (state_next == ADCSC_RESET) && (state_reg != ADCSC_RESET);
  wire cal_done    = (state_reg == ADCSC_CAL) && (state_next == ADCSC_RUN);
  wire running     = (state_reg == ADCSC_RUN);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg     <= ADCSC_RUN;
      trim_cnt_reg  <= 3'h0;
      trim_prev_reg <= 1'b0;
      cal_cnt_reg   <= 16'h0000;
      cal_type_reg  <= 2'h0;
      polarity_reg  <= 1'b0;
    end else begin
      state_reg     <= state_next;
      trim_prev_reg <= trim;
      polarity_reg  <= pin_reg[PIN_POL];
      if (!trim) begin
        trim_cnt_reg <= 3'h0;
      end else if (trim_cnt_reg != TRIM_HOLD_CYC) begin
        trim_cnt_reg <= trim_cnt_reg + 3'h1;
      end
      if (trim_rise) begin
        cal_type_reg <= {pin_reg[PIN_SEL_B], pin_reg[PIN_SEL_A]};
      end
      if (state_reg != ADCSC_CAL) begin
        cal_cnt_reg <= 16'h0000;
      end else begin
        cal_cnt_reg <= cal_cnt_reg + 16'h0001;
      end
    end
  end

  // Output register and word valid flag.
  logic [15:0] word_reg;
  logic        valid_reg;
  // Marks a word loaded during a frame, so that the end of that frame keeps it valid.
  logic        refill_reg;
  logic [2:0]  blank_reg;
  logic        tx_reg;
  logic [4:0]  bit_cnt_reg;
  logic [4:0]  frame_len_reg;
  logic [UART_LEN-1:0] shift_reg;
  logic [1:0]  div_reg;
  logic        sclk_reg;
  logic        sclk_prev_reg;
  logic        serial_out_line_reg;

  wire load     = running && conv_strobe_i;
  wire blanking = (blank_reg != 3'h0);
  wire tx_start = running && !tx_reg && !cs_n && valid_reg && !blanking;
  wire fall_evt = m_self ? sclk_reg : (sclk_prev_reg && !sclk_in);
  wire last_bit = tx_reg && fall_evt && (bit_cnt_reg == frame_len_reg - 5'h1);
  wire tx_abort = tx_reg && (cs_n || !running);

  // Transmit frames: uart puts each byte least significant bit first.
  wire [7:0] hi_rev;
  wire [7:0] lo_rev;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_rev
      assign hi_rev[gi] = word_reg[15-gi];
      assign lo_rev[gi] = word_reg[7-gi];
    end
  endgenerate

  wire [UART_LEN-1:0] uart_frame = {1'b0, hi_rev, 2'b11, 1'b0, lo_rev, 2'b11};
  wire [UART_LEN-1:0] sync_frame = {word_reg, 6'h00};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      word_reg  <= 16'h0000;
      refill_reg <= 1'b0;
      valid_reg <= 1'b0;
      blank_reg <= 3'h0;
    end else begin
      if (enter_reset) begin
        valid_reg <= 1'b0;
        blank_reg <= 3'h0;
      end else if (load) begin
        word_reg  <= conv_word_i;
        valid_reg <= 1'b1;
        blank_reg <= BLANK_CYC;
      end else begin
        if (blanking) begin
          blank_reg <= blank_reg - 3'h1;
        end
        if (last_bit && !refill_reg) begin
          valid_reg <= 1'b0;
        end
      end
      if (enter_reset) begin
        refill_reg <= 1'b0;
      end else if (load && (tx_reg || tx_start)) begin
        refill_reg <= 1'b1;
      end else if (tx_start) begin
        refill_reg <= 1'b0;
      end
    end
  end

  // Serial shifter shared by all three formats.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_reg        <= 1'b0;
      bit_cnt_reg   <= 5'h00;
      frame_len_reg <= SYNC_LEN_C;
      shift_reg     <= '0;
      div_reg       <= 2'h0;
      sclk_reg      <= 1'b0;
      sclk_prev_reg <= 1'b0;
      serial_out_line_reg     <= 1'b1;
    end else begin
      sclk_prev_reg <= sclk_in;
      if (tx_start) begin
        tx_reg        <= 1'b1;
        bit_cnt_reg   <= 5'h00;
        frame_len_reg <= m_uart ? UART_LEN_C : SYNC_LEN_C;
        shift_reg     <= m_uart ? uart_frame : sync_frame;
        serial_out_line_reg     <= m_uart ? 1'b0 : word_reg[WORD_W-1];
        div_reg       <= 2'h0;
        sclk_reg      <= 1'b0;
      end else if (tx_abort || last_bit) begin
        tx_reg    <= 1'b0;
        sclk_reg  <= 1'b0;
        serial_out_line_reg <= 1'b1;
      end else if (tx_reg) begin
        div_reg  <= div_reg + 2'h1;
        sclk_reg <= m_self && (div_reg == SCLK_LAST_PHASE);
        if (fall_evt) begin
          bit_cnt_reg <= bit_cnt_reg + 5'h1;
          shift_reg   <= {shift_reg[UART_LEN-2:0], 1'b0};
          serial_out_line_reg   <= shift_reg[UART_LEN-2];
        end
      end
    end
  end

  assign serial_bit_clock_o    = sclk_reg;
  assign serial_bit_clock_oe_o = m_self;
  assign serial_out_line_o     = serial_out_line_reg;
  assign serial_out_line_oe_o  = tx_reg;
  assign word_valid_n_o        = !(valid_reg && !blanking);
  assign sleep_o               = (state_reg == ADCSC_SLEEP);
  assign bipolar_o             = polarity_reg;
  assign cal_busy_o            = (state_reg == ADCSC_CAL);
  assign cal_type_o            = cal_type_reg;

  // Wishbone slave with one wait state; unmapped reads return zero.
  logic [EVT_W-1:0] status_reg;
  logic [EVT_W-1:0] mask_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;

  wire wb_req   = wb_cyc_i && wb_stb_i;
  wire wb_wr    = wb_req && wb_we_i && ack_reg;
  wire sel_stat = (wb_adr_i == OFS_STATUS);
  wire sel_mask = (wb_adr_i == OFS_MASK);
  wire sel_cal  = (wb_adr_i == OFS_CAL_LEN);

  wire [EVT_W-1:0] evt;
  assign evt[EVT_LOAD]     = load;
  assign evt[EVT_TX_DONE]  = last_bit;
  assign evt[EVT_RESET]    = enter_reset;
  assign evt[EVT_CAL_DONE] = cal_done;

  wire [EVT_W-1:0] w1c = (wb_wr && sel_stat && wb_sel_i[0]) ? wb_dat_i[EVT_W-1:0] : '0;

  wire [31:0] state_word = {16'h0000, 4'h0, state_reg, 1'b0, m_self, m_ext, m_uart,
                            cal_type_reg, polarity_reg, !word_valid_n_o};
  wire [31:0] rd_mux =
      (wb_adr_i == OFS_STATUS)    ? {28'h000_0000, status_reg} :
      (wb_adr_i == OFS_MASK)      ? {28'h000_0000, mask_reg} :
      (wb_adr_i == OFS_STATE)     ? state_word :
      (wb_adr_i == OFS_LAST_WORD) ? {16'h0000, word_reg} :
      (wb_adr_i == OFS_CAL_LEN)   ? {16'h0000, cal_len_reg} : 32'h0000_0000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      status_reg  <= '0;
      mask_reg    <= '0;
      cal_len_reg <= CAL_LEN_RST;
    end else begin
      ack_reg    <= wb_req && !ack_reg;
      rdata_reg  <= rd_mux;
      status_reg <= (status_reg & ~w1c) | evt;
      if (wb_wr && sel_mask && wb_sel_i[0]) begin
        mask_reg <= wb_dat_i[EVT_W-1:0];
      end
      if (wb_wr && sel_cal && wb_sel_i[0]) begin
        cal_len_reg[7:0] <= wb_dat_i[7:0];
      end
      if (wb_wr && sel_cal && wb_sel_i[1]) begin
        cal_len_reg[15:8] <= wb_dat_i[15:8];
      end
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign irq_o    = |(status_reg & mask_reg);

endmodule
`default_nettype wire

// File: verif/adc_serial_output_control_test.sv
// Self-checking bench for the serial output control block.
`default_nettype none
module adc_serial_output_control_test
  import adcsc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic        power_down_n_i = 1'b1, polarity_select_i = 1'b0, trim_request_i = 1'b0;
  logic        sys_trim_sel_a_i = 1'b0, sys_trim_sel_b_i = 1'b0, conv_strobe_i = 1'b0;
  logic        unit_select_n_i, serial_bit_clock_i, hclk, wb_ack_o, irq_o, sleep_o;
  logic        serial_bit_clock_o, serial_bit_clock_oe_o, serial_out_line_o;
  logic        serial_out_line_oe_o, word_valid_n_o, bipolar_o, cal_busy_o;
  logic [1:0]  mode_sel_i = 2'h1;
  logic [1:0]  cal_type_o;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [15:0] conv_word_i = 16'h0000;
  logic [15:0] w;
  logic [21:0] got;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o, q;
  integer      seed = 32'h59fe_990b;
  int          n_mismatch = 0;
  int          n_compared = 0;
  assign serial_bit_clock_i = serial_bit_clock_oe_o ? serial_bit_clock_o : hclk;
  always #4 clk_i = ~clk_i;
  adcsc_top DUT (.*);
  adcsc_host host (
    .sclk_i    (serial_bit_clock_i),
    .line_i    (serial_out_line_o),
    .line_oe_i (serial_out_line_oe_o),
    .mode_i    (mode_sel_i),
    .cs_n_o    (unit_select_n_i),
    .sclk_o    (hclk)
  );
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= wr;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(negedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic load(input logic [15:0] d);
    @(posedge clk_i);
    conv_word_i <= d;
    conv_strobe_i <= 1'b1;
    @(posedge clk_i);
    conv_strobe_i <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  function automatic logic [21:0] expf(input logic [1:0] m, input logic [15:0] d);
    logic [21:0] f;
    f = '0;
    if (m == MODE_UART) f = {2'b11, d[7:0], 1'b0, 2'b11, d[15:8], 1'b0};
    else for (int i = 0; i < 16; i++) f[i] = d[15 - i];
    return f;
  endfunction
  task automatic final_report;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    #100_000;
    n_mismatch++;
    final_report();
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    wb(0, OFS_CAL_LEN, 0);
    chk("cal_len", 32'h0000_0040, q);
    wb(0, 8'h20, 0);
    chk("unmapped", 0, q);
    wb(1, OFS_MASK, 32'h0000_000f);
    wb(1, OFS_CAL_LEN, 32'h0000_0008);
    for (int m = 0; m < 3; m++) begin
      mode_sel_i <= m[1:0];
      w = (m == 1) ? 16'h8001 : 16'($random(seed));
      load(w);
      chk("valid_n", 0, word_valid_n_o);
      wb(0, OFS_LAST_WORD, 0);
      chk("last_word", {16'h0000, w}, q);
      if (m == 1) begin
        host.xfer(0, 1, got);
        repeat (8) @(posedge clk_i);
        chk("abort_oe", 0, serial_out_line_oe_o);
        chk("kept_n", 0, word_valid_n_o);
      end
      host.xfer(m == 0 ? 22 : 16, 0, got);
      chk("frame", expf(m[1:0], w), got);
      repeat (4) @(posedge clk_i);
      chk("done_n", 1, word_valid_n_o);
      chk("irq", 1, irq_o);
      wb(1, OFS_STATUS, 32'h0000_000f);
      chk("irq_clr", 0, irq_o);
      $display("Link test in mode %0d done", m);
    end
    sys_trim_sel_a_i <= 1'b1;
    wb(1, OFS_MASK, 0);
    trim_request_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    trim_request_i <= 1'b0;
    repeat (30) @(posedge clk_i);
    chk("cal_type", 2'b01, cal_type_o);
    chk("busy", 0, cal_busy_o);
    wb(0, OFS_STATUS, 0);
    chk("status", 32'h0000_000c, q);
    chk("masked", 0, irq_o);
    wb(1, OFS_MASK, 32'h0000_0004);
    chk("unmasked", 1, irq_o);
    $display("Calibration test done");
    power_down_n_i <= 1'b0;
    polarity_select_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk("sleep", 1, sleep_o);
    chk("bipolar", 1, bipolar_o);
    load(16'($random(seed)));
    chk("no_load", 1, word_valid_n_o);
    wb(0, OFS_STATE, 0);
    chk("state", 32'h0000_0246, q);
    $display("Sleep test done");
    final_report();
  end
endmodule
`default_nettype wire

// File: verif/adcsc_host.sv
// Host serial port model that selects the device and reads a word, driving the bit clock except in self clocked mode.
`default_nettype none
module adcsc_host
  import adcsc_pkg::*;
(
  input  wire logic       sclk_i,
  input  wire logic       line_i,
  input  wire logic       line_oe_i,
  input  wire logic [1:0] mode_i,
  output logic            cs_n_o,
  output logic            sclk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
  end
  task automatic xfer(input int nb, input bit abort, output logic [21:0] got);
    int k;
    got = '0;
    #3 cs_n_o = 1'b0;
    for (k = 0; k < 60 && !line_oe_i; k++) #8;
    for (k = 0; k < nb && !abort; k++) begin
      if (mode_i[1]) begin
        @(posedge sclk_i);
      end else begin
        sclk_o = 1'b1;
        #32;
      end
      got[k] = line_oe_i ? line_i : 1'bx;
      if (!mode_i[1]) begin
        sclk_o = 1'b0;
        #32;
      end
    end
    #40 cs_n_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: verif/adcsc_top_assertions.sv
// Concurrent checks on the ports of the serial output control block.
`default_nettype none
module adcsc_chk
  import adcsc_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       power_down_n_i,
  input wire logic       trim_request_i,
  input wire logic [1:0] mode_sel_i,
  input wire logic       unit_select_n_i,
  input wire logic       serial_bit_clock_o,
  input wire logic       serial_bit_clock_oe_o,
  input wire logic       serial_out_line_o,
  input wire logic       serial_out_line_oe_o,
  input wire logic       word_valid_n_o,
  input wire logic       conv_strobe_i,
  input wire logic       sleep_o,
  input wire logic       cal_busy_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic load_in_frame;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      load_in_frame <= 1'b0;
    end else if (conv_strobe_i) begin
      load_in_frame <= 1'b1;
    end else if (!serial_out_line_oe_o) begin
      load_in_frame <= 1'b0;
    end
  end
  sleep_entry_a: assert property ($fell(power_down_n_i) ##1 !power_down_n_i[*7] |-> sleep_o)
    else $error("sleep not entered");
  load_blank_a: assert property ((!trim_request_i)[*8] ##0
    (conv_strobe_i && !sleep_o && !cal_busy_o) |=> word_valid_n_o[*4] ##1 !word_valid_n_o)
    else $error("blanking wrong");
  clock_duty_a: assert property (serial_bit_clock_o |=> !serial_bit_clock_o[*3])
    else $error("self clock duty wrong");
  clock_dir_a: assert property ((!rst_i && $stable(mode_sel_i))[*8]
    |-> serial_bit_clock_oe_o == mode_sel_i[1]) else $error("clock direction wrong");
  select_abort_a: assert property ($rose(unit_select_n_i) |-> ##[1:8] !serial_out_line_oe_o)
    else $error("line not released");
  start_bit_a: assert property ($rose(serial_out_line_oe_o) && mode_sel_i == MODE_UART
    |-> !serial_out_line_o) else $error("start bit not low");
  word_done_a: assert property ($fell(serial_out_line_oe_o) && !unit_select_n_i && !sleep_o
    && !load_in_frame |-> ##[0:1] word_valid_n_o) else $error("ready not dropped");
  trim_cal_a: assert property (trim_request_i[*8] ##1 !trim_request_i
    |-> ##[1:8] cal_busy_o) else $error("calibration not started");
  cover property ($rose(serial_out_line_oe_o));
  cover property ($rose(cal_busy_o));
  cover property ($rose(sleep_o));
endmodule
bind adcsc_top adcsc_chk u_chk (.*);
`default_nettype wire
